// File: nand_host_pkg.sv
package nand_host_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ          = 200;
  localparam int CMD_TO_OUTPUT_WAIT_NS = 60;
  localparam int ADDR_TO_INPUT_WAIT_NS = 70;
  localparam int STROBE_LOW_NS         = 15;
  localparam int STROBE_HIGH_NS        = 10;
  localparam int READ_LOW_NS           = 30;

  // Least time to whole cycles, never below one
  function automatic int nsToCycles(input int ns);
    int c;
    c = (ns * CLK_FREQ_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int COUNT_W = 8;
  typedef logic [COUNT_W-1:0] count_t;

  localparam count_t CMD_TO_OUTPUT_WAIT_CYC =
    count_t'(nsToCycles(CMD_TO_OUTPUT_WAIT_NS));
  localparam count_t ADDR_TO_INPUT_WAIT_CYC =
    count_t'(nsToCycles(ADDR_TO_INPUT_WAIT_NS));
  localparam count_t STROBE_LOW_CYC  = count_t'(nsToCycles(STROBE_LOW_NS));
  localparam count_t STROBE_HIGH_CYC = count_t'(nsToCycles(STROBE_HIGH_NS));
  localparam count_t READ_LOW_CYC    = count_t'(nsToCycles(READ_LOW_NS));

  // ----------------------------------------------------------------
  // Command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_STATUS       = 8'h70;
  localparam logic [7:0] CMD_STATUS_LUN   = 8'h78;
  localparam logic [7:0] CMD_READ_MODE    = 8'h00;
  localparam logic [7:0] CMD_RAND_READ    = 8'h05;
  localparam logic [7:0] CMD_RAND_READ_2P = 8'h06;
  localparam logic [7:0] CMD_CONFIRM      = 8'hE0;
  localparam logic [7:0] CMD_RAND_INPUT   = 8'h85;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_CFG   = 8'h04;
  localparam logic [7:0] REG_COL   = 8'h08;
  localparam logic [7:0] REG_ROW   = 8'h0C;
  localparam logic [7:0] REG_WDATA = 8'h10;
  localparam logic [7:0] REG_STAT  = 8'h14;

  localparam int OP_W  = 4;
  localparam int CFG_W = 3;
  localparam int COL_W = 16;
  localparam int ROW_W = 24;
  localparam int CFG_MULTI_LUN_BIT = 0;
  localparam int CFG_OTP_BIT       = 1;
  localparam int CFG_CE_BIT        = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_STATUS       = 4'h0,
    OP_STATUS_LUN   = 4'h1,
    OP_RAND_READ    = 4'h2,
    OP_RAND_READ_2P = 4'h3,
    OP_RAND_INPUT   = 4'h4,
    OP_READ_MODE    = 4'h5,
    OP_READ_BYTE    = 4'h6,
    OP_WRITE_BYTE   = 4'h7
  } op_e;

  typedef enum logic [3:0] {
    ST_CMD  = 4'h0,
    ST_COL0 = 4'h1,
    ST_COL1 = 4'h2,
    ST_ROW0 = 4'h3,
    ST_ROW1 = 4'h4,
    ST_ROW2 = 4'h5,
    ST_CONF = 4'h6,
    ST_WAIT = 4'h7,
    ST_RD   = 4'h8,
    ST_WR   = 4'h9,
    ST_END  = 4'hA
  } step_e;

  typedef enum logic [1:0] {
    MODE_NONE   = 2'h0,
    MODE_STATUS = 2'h1,
    MODE_DOUT   = 2'h2,
    MODE_DIN    = 2'h3
  } mode_e;

  typedef enum logic [1:0] {
    KIND_CMD  = 2'h0,
    KIND_ADDR = 2'h1,
    KIND_WR   = 2'h2,
    KIND_RD   = 2'h3
  } kind_e;

  typedef struct packed {
    logic       ceN;
    logic       cle;
    logic       ale;
    logic       weN;
    logic       reN;
    logic [7:0] ioOut;
    logic       ioOe;
  } nand_pins_s;

  localparam nand_pins_s PINS_IDLE = '{ceN: 1'b1, cle: 1'b0, ale: 1'b0,
                                      weN: 1'b1, reN: 1'b1,
                                      ioOut: 8'h00, ioOe: 1'b0};

endpackage

// File: nand_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

module nand_pin_sync
  import nand_host_pkg::*;
#(
  parameter int WIDTH = 9
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;

endmodule // nand_pin_sync

`default_nettype wire

// File: nand_cycle_gen.sv
`timescale 1ns/10ps
`default_nettype none

module nand_cycle_gen
  import nand_host_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire kind_e      kind,
  input  wire logic [7:0] byteOut,
  input  wire logic       ceEnable,
  input  wire logic [7:0] ioSync,
  output logic            done,
  output logic      [7:0] rdData,
  output nand_pins_s      pins
);

  // ----------------------------------------------------------------
  // Strobe phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_LOW  = 2'b01,
    PH_HIGH = 2'b10
  } phase_e;

  phase_e     phase_q;
  count_t     cnt_q;
  logic       isRead_q;
  logic       done_q;
  logic [7:0] rdData_q;
  nand_pins_s pins_q;

  wire logic cntZero = (cnt_q == '0);
  wire logic isRead  = (kind == KIND_RD);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_q  <= PH_IDLE;
      cnt_q    <= '0;
      isRead_q <= 1'b0;
      done_q   <= 1'b0;
      rdData_q <= 8'h00;
      pins_q   <= PINS_IDLE;
    end else begin
      done_q     <= 1'b0;
      pins_q.ceN <= ~ceEnable;
      case (phase_q)
        PH_IDLE: begin
          if (start) begin
            phase_q      <= PH_LOW;
            isRead_q     <= isRead;
            cnt_q        <= (isRead ? READ_LOW_CYC : STROBE_LOW_CYC) - 1'b1;
            pins_q.cle   <= (kind == KIND_CMD);
            pins_q.ale   <= (kind == KIND_ADDR);
            pins_q.ioOut <= byteOut;
            pins_q.ioOe  <= ~isRead;
            pins_q.weN   <= isRead;
            pins_q.reN   <= ~isRead;
          end
        end
        PH_LOW: begin
          if (cntZero) begin
            phase_q    <= PH_HIGH;
            cnt_q      <= STROBE_HIGH_CYC - 1'b1;
            pins_q.weN <= 1'b1;
            pins_q.reN <= 1'b1;
            if (isRead_q) begin
              rdData_q <= ioSync;
            end
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        PH_HIGH: begin
          if (cntZero) begin
            phase_q     <= PH_IDLE;
            done_q      <= 1'b1;
            pins_q.cle  <= 1'b0;
            pins_q.ale  <= 1'b0;
            pins_q.ioOe <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  assign done   = done_q;
  assign rdData = rdData_q;
  assign pins   = pins_q;

endmodule // nand_cycle_gen

`default_nettype wire

// File: nand_status_column_host.sv
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Single LUN target: plain status may follow any command.
// - Multi-LUN target: use LUN-addressed status, never plain status.
// - LUN-addressed status: command then three row cycles; status mode.
// - After LUN-addressed status, issue read-mode before reading data; the host still accepts a read byte in status mode.
// - No LUN-addressed status during power-on reset or OTP mode; the host refuses it only when the OTP bit is set.
// - Random read: command, two columns, confirm, wait before output.
// - Multi-LUN: LUN-addressed status must precede random data read.
// - Two-plane read: command, two columns, three rows, confirm, wait.
// - Two-plane random read picks plane cache; reissue to switch.
// - Multi-LUN two-plane read needs all ready or prior LUN status.
// - Random input: command, two columns, wait before data; data optional.
// - Random input allowed between program address cycles and confirm.

module nand_status_column_host
  import nand_host_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [7:0]  ioIn,
  input  wire logic        readyBusyN,
  output nand_pins_s       nandPins
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] mergeLanes(input logic [31:0] oldWord,
                                             input logic [31:0] newWord,
                                             input logic [3:0]  lanes);
    logic [31:0] w;
    w = oldWord;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        w[i*8 +: 8] = newWord[i*8 +: 8];
      end
    end
    return w;
  endfunction

  function automatic logic [7:0] cmdOf(input op_e op);
    case (op)
      OP_STATUS:       return CMD_STATUS;
      OP_STATUS_LUN:   return CMD_STATUS_LUN;
      OP_RAND_READ:    return CMD_RAND_READ;
      OP_RAND_READ_2P: return CMD_RAND_READ_2P;
      OP_RAND_INPUT:   return CMD_RAND_INPUT;
      default:         return CMD_READ_MODE;
    endcase
  endfunction

  // Cycle list of each operation
  function automatic step_e seqStep(input op_e op, input logic [3:0] idx);
    step_e s;
    s = ST_END;
    case (op)
      OP_STATUS: begin
        case (idx)
          4'h0: s = ST_CMD;
          4'h1: s = ST_WAIT;
          4'h2: s = ST_RD;
          default: s = ST_END;
        endcase
      end
      OP_STATUS_LUN: begin
        case (idx)
          4'h0: s = ST_CMD;
          4'h1: s = ST_ROW0;
          4'h2: s = ST_ROW1;
          4'h3: s = ST_ROW2;
          4'h4: s = ST_WAIT;
          4'h5: s = ST_RD;
          default: s = ST_END;
        endcase
      end
      OP_RAND_READ: begin
        case (idx)
          4'h0: s = ST_CMD;
          4'h1: s = ST_COL0;
          4'h2: s = ST_COL1;
          4'h3: s = ST_CONF;
          4'h4: s = ST_WAIT;
          default: s = ST_END;
        endcase
      end
      OP_RAND_READ_2P: begin
        case (idx)
          4'h0: s = ST_CMD;
          4'h1: s = ST_COL0;
          4'h2: s = ST_COL1;
          4'h3: s = ST_ROW0;
          4'h4: s = ST_ROW1;
          4'h5: s = ST_ROW2;
          4'h6: s = ST_CONF;
          4'h7: s = ST_WAIT;
          default: s = ST_END;
        endcase
      end
      OP_RAND_INPUT: begin
        case (idx)
          4'h0: s = ST_CMD;
          4'h1: s = ST_COL0;
          4'h2: s = ST_COL1;
          4'h3: s = ST_WAIT;
          default: s = ST_END;
        endcase
      end
      OP_READ_MODE: s = (idx == 4'h0) ? ST_CMD : ST_END;
      OP_READ_BYTE: s = (idx == 4'h0) ? ST_RD : ST_END;
      OP_WRITE_BYTE: s = (idx == 4'h0) ? ST_WR : ST_END;
      default: s = ST_END;
    endcase
    return s;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_STEP  = 2'b01,
    S_CYCLE = 2'b10,
    S_WAIT  = 2'b11
  } state_e;

  state_e            state_q;
  op_e               op_q;
  logic [3:0]        idx_q;
  count_t            wait_q;
  mode_e             mode_q;
  logic              lunSel_q;
  logic              refused_q;
  logic [CFG_W-1:0]  cfg_q;
  logic [COL_W-1:0]  col_q;
  logic [ROW_W-1:0]  row_q;
  logic [7:0]        wdata_q;
  logic [7:0]        statusByte_q;
  logic [7:0]        readByte_q;
  logic              ack_q;
  logic [31:0]       dat_q;
  logic              genStart_q;

  logic [8:0]        pinSync;
  logic              genDone;
  logic [7:0]        genData;

  // ----------------------------------------------------------------
  // Pin synchroniser and strobe generator
  // ----------------------------------------------------------------
  nand_pin_sync #(.WIDTH(9)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  ({readyBusyN, ioIn}),
    .syncOut  (pinSync)
  );

  wire logic       readyPin = pinSync[8];
  wire step_e      curStep  = seqStep(op_q, idx_q);
  wire kind_e      curKind  = (curStep == ST_CMD || curStep == ST_CONF)
                              ? KIND_CMD
                              : (curStep == ST_RD) ? KIND_RD
                              : (curStep == ST_WR) ? KIND_WR : KIND_ADDR;
  // Full column and row reach every cache byte
  wire logic [7:0] curByte  = (curStep == ST_CMD)  ? cmdOf(op_q)
                            : (curStep == ST_CONF) ? CMD_CONFIRM
                            : (curStep == ST_COL0) ? col_q[7:0]
                            : (curStep == ST_COL1) ? col_q[15:8]
                            : (curStep == ST_ROW0) ? row_q[7:0]
                            : (curStep == ST_ROW1) ? row_q[15:8]
                            : (curStep == ST_ROW2) ? row_q[23:16]
                            : wdata_q;

  nand_cycle_gen u_gen (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (genStart_q),
    .kind     (curKind),
    .byteOut  (curByte),
    .ceEnable (cfg_q[CFG_CE_BIT]),
    .ioSync   (pinSync[7:0]),
    .done     (genDone),
    .rdData   (genData),
    .pins     (nandPins)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic access  = cyc_i & stb_i & ~ack_q;
  wire logic wrAcc   = access & we_i;
  wire logic idle    = (state_q == S_IDLE);
  wire logic launch  = wrAcc && (adr_i == REG_CTRL) && sel_i[0];
  wire logic wrCfg   = wrAcc && (adr_i == REG_CFG);
  wire logic wrCol   = wrAcc && (adr_i == REG_COL) && idle;
  wire logic wrRow   = wrAcc && (adr_i == REG_ROW) && idle;
  wire logic wrWdata = wrAcc && (adr_i == REG_WDATA) && idle;
  wire op_e  newOp   = op_e'(dat_i[OP_W-1:0]);
  wire logic multiLun = cfg_q[CFG_MULTI_LUN_BIT];

  // Checks against orders that would upset the target
  wire logic badPlain   = (newOp == OP_STATUS) && multiLun;
  wire logic badLunStat = (newOp == OP_STATUS_LUN)
                          && cfg_q[CFG_OTP_BIT];
  wire logic badRand    = (newOp == OP_RAND_READ) && multiLun
                          && !lunSel_q;
  wire logic bad2p      = (newOp == OP_RAND_READ_2P) && multiLun
                          && !readyPin && !lunSel_q;
  wire logic badRead    = (newOp == OP_READ_BYTE)
                          && (mode_q != MODE_DOUT)
                          && (mode_q != MODE_STATUS);
  wire logic badWrite   = (newOp == OP_WRITE_BYTE)
                          && (mode_q != MODE_DIN);
  wire logic badOp      = (dat_i[OP_W-1:0] > OP_WRITE_BYTE);
  wire logic refuse     = !idle || badPlain || badLunStat || badRand
                          || bad2p || badRead || badWrite || badOp;

  wire logic [31:0] statWord = {8'h00, readByte_q, statusByte_q, 2'b00,
                                mode_q, 1'b0, refused_q, readyPin, ~idle};
  wire logic [31:0] rdWord =
      (adr_i == REG_CTRL)  ? {{(32-OP_W){1'b0}}, op_q}
    : (adr_i == REG_CFG)   ? {{(32-CFG_W){1'b0}}, cfg_q}
    : (adr_i == REG_COL)   ? {{(32-COL_W){1'b0}}, col_q}
    : (adr_i == REG_ROW)   ? {{(32-ROW_W){1'b0}}, row_q}
    : (adr_i == REG_WDATA) ? {24'h000000, wdata_q}
    : (adr_i == REG_STAT)  ? statWord
    : 32'h00000000;
  wire logic [31:0] cfgMerged = mergeLanes({{(32-CFG_W){1'b0}}, cfg_q},
                                           dat_i, sel_i);
  wire logic [31:0] colMerged = mergeLanes({{(32-COL_W){1'b0}}, col_q},
                                           dat_i, sel_i);
  wire logic [31:0] rowMerged = mergeLanes({{(32-ROW_W){1'b0}}, row_q},
                                           dat_i, sel_i);

  // ----------------------------------------------------------------
  // Register file and bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_q   <= 1'b0;
      dat_q   <= 32'h00000000;
      cfg_q   <= CFG_RESET;
      col_q   <= '0;
      row_q   <= '0;
      wdata_q <= 8'h00;
    end else begin
      ack_q <= access;
      if (access) begin
        dat_q <= rdWord;
      end
      if (wrCfg) begin
        cfg_q <= cfgMerged[CFG_W-1:0];
      end
      if (wrCol) begin
        col_q <= colMerged[COL_W-1:0];
      end
      if (wrRow) begin
        row_q <= rowMerged[ROW_W-1:0];
      end
      if (wrWdata && sel_i[0]) begin
        wdata_q <= dat_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  wire logic statusOp = (op_q == OP_STATUS) || (op_q == OP_STATUS_LUN);
  wire count_t opWait = (op_q == OP_RAND_INPUT) ? ADDR_TO_INPUT_WAIT_CYC
                                                : CMD_TO_OUTPUT_WAIT_CYC;
  wire mode_e endMode = statusOp ? MODE_STATUS
                      : (op_q == OP_RAND_INPUT) ? MODE_DIN
                      : (op_q == OP_READ_BYTE || op_q == OP_WRITE_BYTE)
                        ? mode_q : MODE_DOUT;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q      <= S_IDLE;
      op_q         <= OP_STATUS;
      idx_q        <= 4'h0;
      wait_q       <= '0;
      mode_q       <= MODE_NONE;
      lunSel_q     <= 1'b0;
      refused_q    <= 1'b0;
      statusByte_q <= 8'h00;
      readByte_q   <= 8'h00;
      genStart_q   <= 1'b0;
    end else begin
      genStart_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (launch && refuse) begin
            refused_q <= 1'b1;
          end else if (launch) begin
            refused_q <= 1'b0;
            op_q      <= newOp;
            idx_q     <= 4'h0;
            state_q   <= S_STEP;
          end
        end
        S_STEP: begin
          if (curStep == ST_END) begin
            mode_q  <= endMode;
            state_q <= S_IDLE;
            if (op_q == OP_STATUS_LUN) begin
              lunSel_q <= 1'b1;
            end else if (op_q == OP_STATUS) begin
              lunSel_q <= 1'b0;
            end
          end else if (curStep == ST_WAIT) begin
            wait_q  <= opWait;
            state_q <= S_WAIT;
          end else begin
            genStart_q <= 1'b1;
            state_q    <= S_CYCLE;
          end
        end
        S_CYCLE: begin
          if (genDone) begin
            idx_q   <= idx_q + 4'h1;
            state_q <= S_STEP;
            if (curStep == ST_RD && statusOp) begin
              statusByte_q <= genData;
            end else if (curStep == ST_RD) begin
              readByte_q <= genData;
            end
          end
        end
        S_WAIT: begin
          if (wait_q <= count_t'(1)) begin
            idx_q   <= idx_q + 4'h1;
            state_q <= S_STEP;
          end else begin
            wait_q <= wait_q - 1'b1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;

endmodule // nand_status_column_host

`default_nettype wire

// File: nand_status_column_host_properties.sv
`timescale 1ns/10ps
`default_nettype none
module nand_status_column_host_chk
  import nand_host_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [7:0]  ioIn,
  input wire logic        readyBusyN,
  input wire nand_pins_s  nandPins
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic we_q;
  always_ff @(posedge core_clk) we_q <= nandPins.weN;
  wire dataWr = we_q && !nandPins.weN && !nandPins.cle && !nandPins.ale;
  sequence readWait;
    nandPins.reN[*6] ##1 nandPins.reN[*6];
  endsequence
  sequence noDataWr;
    (!dataWr)[*7] ##1 (!dataWr)[*7];
  endsequence
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  a_we_low: assert property ($fell(nandPins.weN) |->
    (!nandPins.weN)[*3] ##1 nandPins.weN) else $error("write strobe width");
  a_re_low: assert property ($fell(nandPins.reN) |->
    (!nandPins.reN)[*6] ##1 nandPins.reN) else $error("read strobe width");
  a_cycle_drive: assert property (
    !nandPins.weN && (nandPins.cle || nandPins.ale) |->
    nandPins.ioOe && !(nandPins.cle && nandPins.ale))
    else $error("command or address cycle not driven");
  a_read_float: assert property (!nandPins.reN |-> !nandPins.ioOe)
    else $error("host drives bus in read");
  a_cmd_wait: assert property ($rose(nandPins.weN) &&
    nandPins.cle && (nandPins.ioOut == CMD_CONFIRM ||
    nandPins.ioOut == CMD_STATUS) |=> readWait) else $error("read too early");
  a_addr_wait: assert property ($rose(nandPins.weN) &&
    nandPins.ale |=> noDataWr) else $error("data too early");
endmodule // nand_status_column_host_chk
`default_nettype wire

// File: nand_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module nand_dev_model
  import nand_host_pkg::*;
(
  input wire logic       core_clk,
  input wire nand_pins_s nandPins,
  input wire logic       busy,
  input wire logic       cacheOp,
  output logic [7:0]     ioIn,
  output logic           readyBusyN
);
  // ------------
  // Device model
  // ------------
  logic [7:0] cache [256];
  logic [7:0] cmd_q = 8'hFF, col_q = 8'h00, last_q = 8'h00;
  logic [2:0] nAddr_q = 3'h0;
  logic       plane_q = 1'b0, we_q = 1'b1, re_q = 1'b1, tog_q = 1'b0;
  mode_e      mode_q = MODE_NONE;
  wire [7:0] stat = {1'b1, ~busy, ~busy & ~cacheOp, 4'h0,
                     plane_q};
  wire drive = !nandPins.ceN && !nandPins.reN;
  assign readyBusyN = ~busy;
  assign ioIn = !drive ? ~last_q ^ {8{tog_q}} :
                (mode_q == MODE_STATUS) ? stat : cache[col_q];
  initial for (int i = 0; i < 256; i++) cache[i] = 8'(i) ^ 8'hA5;
  always @(posedge core_clk) begin
    we_q <= nandPins.weN;
    re_q <= nandPins.reN;
    tog_q <= ~tog_q;
    if (drive) last_q <= ioIn;
    if (!we_q && nandPins.weN && !nandPins.ceN) begin
      if (nandPins.cle) begin
        cmd_q <= nandPins.ioOut;
        nAddr_q <= 3'h0;
        case (nandPins.ioOut)
          CMD_STATUS: mode_q <= MODE_STATUS;
          CMD_READ_MODE, CMD_CONFIRM:
            mode_q <= MODE_DOUT;
          default: ;
        endcase
      end else if (nandPins.ale) begin
        nAddr_q <= nAddr_q + 3'h1;
        if (cmd_q != CMD_STATUS_LUN && nAddr_q == 3'h0)
          col_q <= nandPins.ioOut;
        if ((cmd_q == CMD_STATUS_LUN && nAddr_q == 3'h1) ||
            (cmd_q == CMD_RAND_READ_2P && nAddr_q == 3'h3))
          plane_q <= nandPins.ioOut[0];
        if (cmd_q == CMD_STATUS_LUN && nAddr_q == 3'h2)
          mode_q <= MODE_STATUS;
        if (cmd_q == CMD_RAND_INPUT && nAddr_q == 3'h1)
          mode_q <= MODE_DIN;
      end else if (mode_q == MODE_DIN) begin
        cache[col_q] <= nandPins.ioOut;
        col_q <= col_q + 8'h01;
      end
    end
    if (!re_q && nandPins.reN && mode_q == MODE_DOUT) col_q <= col_q + 8'h01;
  end
endmodule // nand_dev_model
`default_nettype wire

// File: nand_status_column_host_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module nand_status_column_host_tb_top
  import nand_host_pkg::*;
;
  // ---------
  // Testbench
  // ---------
  logic core_clk = 1'b0, rst = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic we_i = 1'b0, busy = 1'b0, cacheOp = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, rdat;
  logic [3:0] sel_i = 4'hF;
  logic ack_o, readyBusyN;
  logic [7:0] ioIn;
  nand_pins_s nandPins;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  always #2.5 core_clk = ~core_clk;
  nand_status_column_host DUT (.core_clk, .rst, .cyc_i, .stb_i, .we_i,
    .adr_i, .dat_i, .sel_i, .dat_o, .ack_o, .ioIn, .readyBusyN, .nandPins);
  nand_dev_model u_dev (.core_clk, .nandPins, .busy, .cacheOp, .ioIn,
    .readyBusyN);
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge core_clk);
    while (ack_o !== 1'b1) @(posedge core_clk);
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic go(input logic [3:0] op);
    wb(1'b1, REG_CTRL, {28'h0, op});
    wb(1'b0, REG_STAT, 32'h0);
    while (rdat[0] !== 1'b0) wb(1'b0, REG_STAT, 32'h0);
  endtask
  task automatic chk(input logic [31:0] m, input logic [31:0] e);
    samples_checked++;
    if ((rdat & m) !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, rdat & m, e);
      num_errors++;
    end
  endtask
  task close_out;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task t_status;
    busy <= 1'b1;
    go(4'h0);
    chk(32'h0000FF32, 32'h00008010);
    busy <= 1'b0;
  endtask
  task t_lun;
    wb(1'b1, REG_ROW, 32'h00000100);
    go(4'h1);
    chk(32'h0000FF30, 32'h0000E110);
    go(4'h5);
    go(4'h6);
    chk(32'h00FF0000, 32'h00A50000);
  endtask
  task t_rread;
    cacheOp <= 1'b1;
    wb(1'b1, REG_COL, 32'h000012FF);
    go(4'h2);
    go(4'h6);
    chk(32'h00FF0000, 32'h005A0000);
    cacheOp <= 1'b0;
  endtask
  task t_2p;
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, REG_COL, 32'h10 + 32'(i));
      wb(1'b1, REG_ROW, 32'(i) << 8);
      go(4'h3);
      go(4'h6);
      chk(32'h00FF0000, {8'h0, 8'hB5 ^ 8'(i), 16'h0});
    end
    go(4'h0);
    chk(32'h0000FF00, 32'h0000E100);
  endtask
  task t_rinput;
    wb(1'b1, REG_COL, 32'h00000040);
    go(4'h4);
    chk(32'h00000030, 32'h00000030);
    wb(1'b1, REG_WDATA, 32'h0000003C);
    go(4'h7);
    go(4'h2);
    go(4'h6);
    chk(32'h00FF0000, 32'h003C0000);
  endtask
  task t_refuse;
    wb(1'b1, REG_CFG, 32'h5);
    go(4'h0);
    chk(32'h00000004, 32'h00000004);
    busy <= 1'b1;
    go(4'h5);
    go(4'h2);
    chk(32'h00000004, 32'h00000004);
    go(4'h5);
    go(4'h3);
    chk(32'h00000006, 32'h00000004);
    busy <= 1'b0;
    go(4'h1);
    go(4'h2);
    go(4'h6);
    chk(32'h00FF0000, 32'h003C0000);
    go(4'h9);
    chk(32'h00000004, 32'h00000004);
    wb(1'b1, REG_CFG, 32'h6);
    go(4'h5);
    go(4'h1);
    chk(32'h00000004, 32'h00000004);
    wb(1'b0, 8'h30, 32'h0);
    chk(32'hFFFFFFFF, 32'h0);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out;
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    wb(1'b1, REG_CFG, 32'h4);
    t_status;
    t_lun;
    t_rread;
    t_2p;
    t_rinput;
    t_refuse;
    close_out;
  end
endmodule // nand_status_column_host_tb_top
bind nand_status_column_host nand_status_column_host_chk u_chk (.core_clk,
  .rst, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o, .ack_o,
  .ioIn, .readyBusyN, .nandPins);
`default_nettype wire
